// file: verilog/msc_pkg.sv
// Purpose: constants, field layout, decode tables and carriers for the motor start-up config
// Assumes: 16-bit configuration words at byte-wide register addresses
// Notes: decoded values are fixed-point integers; units are given beside each field

package msc_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] MSC_ADDR_BRAKE = 8'h92;
  localparam logic [7:0] MSC_ADDR_ACCEL = 8'h93;
  localparam logic [15:0] MSC_WORD_RESET = 16'h0000;
  localparam logic [15:0] MSC_ACCEL_WMASK = 16'h7fff;
  localparam logic [15:0] MSC_READ_IDLE = 16'h0000;

  // ------------------------------------------------------------
  // field positions, brake word
  // ------------------------------------------------------------
  localparam int MSC_STAT_LSB = 14;
  localparam int MSC_BRKCUR_BIT = 13;
  localparam int MSC_HYS_BIT = 12;
  localparam int MSC_ISD_BIT = 11;
  localparam int MSC_RVS_EN_BIT = 10;
  localparam int MSC_RVS_THR_LSB = 8;
  localparam int MSC_OLCUR_LSB = 6;
  localparam int MSC_RAMP_LSB = 3;
  localparam int MSC_BRKDUR_LSB = 0;

  // ------------------------------------------------------------
  // field positions, acceleration word
  // ------------------------------------------------------------
  localparam int MSC_RSVD_BIT = 15;
  localparam int MSC_RANGE_BIT = 14;
  localparam int MSC_ACC2_LSB = 11;
  localparam int MSC_ACC1_LSB = 8;
  localparam int MSC_HO_LSB = 3;
  localparam int MSC_ALIGN_LSB = 0;

  // ------------------------------------------------------------
  // scalar settings
  // ------------------------------------------------------------
  localparam logic [7:0] MSC_BRK_CUR_LO_MA = 8'h18;
  localparam logic [7:0] MSC_BRK_CUR_HI_MA = 8'h30;
  localparam logic [7:0] MSC_HYS_LO_MV = 8'h14;
  localparam logic [7:0] MSC_HYS_HI_MV = 8'h28;
  localparam logic [15:0] MSC_STAT_BASE_MS = 16'h0050;
  localparam logic [15:0] MSC_ALIGN_LONG_MS = 16'h14b4;
  localparam logic [11:0] MSC_HO_STEP_LO = 12'h008;
  localparam logic [11:0] MSC_HO_STEP_HI = 12'h080;
  localparam logic [11:0] MSC_HO_BASE_HI = 12'h077;
  localparam logic [2:0] MSC_BRAKE_OFF = 3'h0;

  // stationary: 0.1 Hz units, ms; reverse threshold: 0.1 Hz; currents: mA;
  // ramp: milli-supply-volts per second; durations: ms
  typedef struct packed {
    logic [15:0] stationary_freq;
    logic [15:0] stationary_ms;
    logic [7:0] brake_current_ma;
    logic [7:0] hysteresis_mv;
    logic initial_speed_detect_enable;
    logic reverse_drive_enable;
    logic [15:0] reverse_threshold;
    logic [11:0] open_loop_current_ma;
    logic [11:0] align_current_ma;
    logic [15:0] ramp_rate;
    logic brake_enable;
    logic [15:0] brake_duration_ms;
  } msc_brake_t;

  // accel2: 0.1 mHz/s^2; accel1: mHz/s; handover: 0.1 Hz; align: ms
  typedef struct packed {
    logic range_slow;
    logic [19:0] accel_second_order;
    logic [16:0] accel_first_order;
    logic handover_valid;
    logic [11:0] handover_freq;
    logic [15:0] align_ms;
  } msc_accel_t;

  // ------------------------------------------------------------
  // lookup functions
  // ------------------------------------------------------------
  // code 0 reads as zero so the brake path sees "disabled"
  function automatic logic [15:0] msc_duration_ms(input logic [2:0] code);
    unique case (code)
      3'h0: msc_duration_ms = 16'h0000;
      3'h1: msc_duration_ms = 16'h0a8c;
      3'h2: msc_duration_ms = 16'h0514;
      3'h3: msc_duration_ms = 16'h029e;
      3'h4: msc_duration_ms = 16'h014a;
      3'h5: msc_duration_ms = 16'h00a0;
      3'h6: msc_duration_ms = 16'h0050;
      3'h7: msc_duration_ms = 16'h0028;
    endcase
  endfunction

  function automatic logic [19:0] msc_accel2(input logic slow, input logic [2:0] code);
    unique case ({slow, code})
      4'h0: msc_accel2 = 20'h8b290;
      4'h1: msc_accel2 = 20'h46cd0;
      4'h2: msc_accel2 = 20'h222e0;
      4'h3: msc_accel2 = 20'h10d88;
      4'h4: msc_accel2 = 20'h080e8;
      4'h5: msc_accel2 = 20'h03e80;
      4'h6: msc_accel2 = 20'h019c8;
      4'h8: msc_accel2 = 20'h00898;
      4'h9: msc_accel2 = 20'h0044c;
      4'ha: msc_accel2 = 20'h00226;
      4'hb: msc_accel2 = 20'h0010e;
      4'hc: msc_accel2 = 20'h00082;
      4'hd: msc_accel2 = 20'h0003f;
      4'he: msc_accel2 = 20'h0001e;
      default: msc_accel2 = 20'h00000;
    endcase
  endfunction

  function automatic logic [16:0] msc_accel1(input logic slow, input logic [2:0] code);
    unique case ({slow, code})
      4'h0: msc_accel1 = 17'h128e0;
      4'h1: msc_accel1 = 17'h09470;
      4'h2: msc_accel1 = 17'h04a38;
      4'h3: msc_accel1 = 17'h023f0;
      4'h4: msc_accel1 = 17'h01194;
      4'h5: msc_accel1 = 17'h00834;
      4'h6: msc_accel1 = 17'h00384;
      4'h7: msc_accel1 = 17'h0012c;
      4'h8: msc_accel1 = 17'h012c0;
      4'h9: msc_accel1 = 17'h00960;
      4'ha: msc_accel1 = 17'h004b0;
      4'hb: msc_accel1 = 17'h00244;
      4'hc: msc_accel1 = 17'h00118;
      4'hd: msc_accel1 = 17'h00082;
      4'he: msc_accel1 = 17'h00038;
      4'hf: msc_accel1 = 17'h00013;
    endcase
  endfunction

endpackage

// file: verilog/msc_brake_decode.sv
// Purpose: decode the brake/start word into registered operating parameters
// Assumes: word is stable between start-up events
// Notes: one cycle from word to parameters

`timescale 1ns/1ps

module msc_brake_decode
  import msc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [15:0] word_in,
  output msc_brake_t params_out
);

  // ------------------------------------------------------------
  // field decode
  // ------------------------------------------------------------
  wire [1:0] stat_code = word_in[MSC_STAT_LSB +: 2];
  wire [1:0] rvs_code = word_in[MSC_RVS_THR_LSB +: 2];
  wire [1:0] cur_code = word_in[MSC_OLCUR_LSB +: 2];
  wire [2:0] ramp_code = word_in[MSC_RAMP_LSB +: 3];
  wire [2:0] brk_code = word_in[MSC_BRKDUR_LSB +: 3];
  logic [15:0] stat_freq;
  logic [15:0] rvs_thr;
  logic [11:0] ol_cur;
  logic [11:0] al_cur;
  logic [15:0] ramp;
  msc_brake_t next_params;

  always_comb begin
    unique case (stat_code)
      2'h0: stat_freq = 16'h003c;
      2'h1: stat_freq = 16'h001e;
      2'h2: stat_freq = 16'h0010;
      2'h3: stat_freq = 16'h0008;
    endcase
    unique case (rvs_code)
      2'h0: rvs_thr = 16'h003f;
      2'h1: rvs_thr = 16'h0082;
      2'h2: rvs_thr = 16'h0104;
      2'h3: rvs_thr = 16'h01fe;
    endcase
    // one field drives both currents
    unique case (cur_code)
      2'h0: begin ol_cur = 12'h0c8; al_cur = 12'h096; end
      2'h1: begin ol_cur = 12'h190; al_cur = 12'h12c; end
      2'h2: begin ol_cur = 12'h320; al_cur = 12'h258; end
      2'h3: begin ol_cur = 12'h640; al_cur = 12'h4b0; end
    endcase
    unique case (ramp_code)
      3'h0: ramp = 16'h1770;
      3'h1: ramp = 16'h0bb8;
      3'h2: ramp = 16'h05dc;
      3'h3: ramp = 16'h02bc;
      3'h4: ramp = 16'h0154;
      3'h5: ramp = 16'h00a0;
      3'h6: ramp = 16'h0046;
      3'h7: ramp = 16'h0017;
    endcase
  end

  assign next_params.stationary_freq = stat_freq;
  assign next_params.stationary_ms = MSC_STAT_BASE_MS << stat_code;
  assign next_params.brake_current_ma = word_in[MSC_BRKCUR_BIT] ?
      MSC_BRK_CUR_HI_MA : MSC_BRK_CUR_LO_MA;
  assign next_params.hysteresis_mv = word_in[MSC_HYS_BIT] ? MSC_HYS_HI_MV : MSC_HYS_LO_MV;
  assign next_params.initial_speed_detect_enable = word_in[MSC_ISD_BIT];
  assign next_params.reverse_drive_enable = word_in[MSC_RVS_EN_BIT];
  assign next_params.reverse_threshold = rvs_thr;
  assign next_params.open_loop_current_ma = ol_cur;
  assign next_params.align_current_ma = al_cur;
  assign next_params.ramp_rate = ramp;
  assign next_params.brake_enable = (brk_code != MSC_BRAKE_OFF);
  assign next_params.brake_duration_ms = msc_duration_ms(brk_code);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      params_out <= '0;
    end else begin
      params_out <= next_params;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  chk_stationary_slowest: assert property (stat_code == 2'h3 |=>
      params_out.stationary_ms == 16'h0280 && params_out.stationary_freq == 16'h0008)
    else $error("stationary threshold decode wrong");
  chk_brake_current_sel: assert property (word_in[MSC_BRKCUR_BIT] |=>
      params_out.brake_current_ma == 8'h30)
    else $error("brake current select wrong");
  chk_hysteresis_low: assert property (!word_in[MSC_HYS_BIT] |=>
      params_out.hysteresis_mv == 8'h14)
    else $error("hysteresis decode wrong");
  chk_speed_detect_en: assert property (params_out.initial_speed_detect_enable ==
      $past(word_in[MSC_ISD_BIT]) || $past(rst_in))
    else $error("speed detect enable mismatch");
  chk_reverse_en: assert property (params_out.reverse_drive_enable ==
      $past(word_in[MSC_RVS_EN_BIT]) || $past(rst_in))
    else $error("reverse drive enable mismatch");
  chk_reverse_thr_top: assert property (rvs_code == 2'h3 |=>
      params_out.reverse_threshold == 16'h01fe)
    else $error("reverse threshold decode wrong");
  chk_current_pair: assert property (cur_code == 2'h2 |=>
      params_out.open_loop_current_ma == 12'h320 && params_out.align_current_ma == 12'h258)
    else $error("open-loop or align current wrong");
  chk_ramp_slowest: assert property (ramp_code == 3'h7 |=> params_out.ramp_rate == 16'h0017)
    else $error("ramp rate decode wrong");
  chk_brake_disabled: assert property (brk_code == 3'h0 |=>
      !params_out.brake_enable && params_out.brake_duration_ms == 16'h0000)
    else $error("brake not disabled at code zero");
  chk_brake_longest: assert property (brk_code == 3'h1 |=>
      params_out.brake_enable && params_out.brake_duration_ms == 16'h0a8c)
    else $error("brake duration decode wrong");

endmodule

// file: verilog/msc_accel_decode.sv
// Purpose: decode the acceleration/handover/align word into registered parameters
// Assumes: word is stable between start-up events
// Notes: one cycle from word to parameters

`timescale 1ns/1ps

module msc_accel_decode
  import msc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [15:0] word_in,
  output msc_accel_t params_out
);

  wire slow = word_in[MSC_RANGE_BIT];
  wire [2:0] acc2_code = word_in[MSC_ACC2_LSB +: 3];
  wire [2:0] acc1_code = word_in[MSC_ACC1_LSB +: 3];
  wire [4:0] ho_code = word_in[MSC_HO_LSB +: 5];
  wire [2:0] align_code = word_in[MSC_ALIGN_LSB +: 3];
  // range 0 is n steps, range 1 restarts from an offset with a wider step
  wire [11:0] ho_lo = 12'({7'h00, ho_code} * MSC_HO_STEP_LO);
  wire [11:0] ho_hi = 12'(({8'h00, ho_code[3:0]} * MSC_HO_STEP_HI) + MSC_HO_BASE_HI);
  msc_accel_t next_params;

  assign next_params.range_slow = slow;
  assign next_params.accel_second_order = msc_accel2(slow, acc2_code);
  assign next_params.accel_first_order = msc_accel1(slow, acc1_code);
  assign next_params.handover_freq = ho_code[4] ? ho_hi : ho_lo;
  assign next_params.handover_valid = (ho_code != 5'h00);
  assign next_params.align_ms = (align_code == 3'h0) ? MSC_ALIGN_LONG_MS :
      msc_duration_ms(align_code);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      params_out <= '0;
    end else begin
      params_out <= next_params;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  chk_range_fast_first: assert property (!slow && acc1_code == 3'h0 |=>
      params_out.accel_first_order == 17'h128e0 && !params_out.range_slow)
    else $error("fast range first-order decode wrong");
  chk_accel2_zero_top: assert property (acc2_code == 3'h7 |=>
      params_out.accel_second_order == 20'h00000)
    else $error("second-order top code not zero");
  chk_accel2_slow_base: assert property (slow && acc2_code == 3'h0 |=>
      params_out.accel_second_order == 20'h00898)
    else $error("second-order slow base wrong");
  chk_accel1_slow_min: assert property (slow && acc1_code == 3'h7 |=>
      params_out.accel_first_order == 17'h00013)
    else $error("first-order slow minimum wrong");
  chk_handover_lo_range: assert property (!ho_code[4] |=>
      params_out.handover_freq == 12'($past(ho_code) * 8) &&
      params_out.handover_valid == ($past(ho_code) != 5'h00))
    else $error("handover range 0 wrong");
  chk_handover_top: assert property (ho_code == 5'h1f |=>
      params_out.handover_freq == 12'h7f7 && params_out.handover_valid)
    else $error("handover top code wrong");
  chk_handover_hi_base: assert property (ho_code == 5'h10 |=>
      params_out.handover_freq == 12'h077)
    else $error("handover range 1 base wrong");
  chk_align_times: assert property (align_code == 3'h0 |=> params_out.align_ms == 16'h14b4
      ##0 $past(align_code, 1) == 3'h0)
    else $error("align time decode wrong");

endmodule

// file: verilog/msc_startup_config.sv
// Purpose: start-up/brake configuration words, register access and start-up snapshot
// Assumes: register port already decoded from the serial interface, one access a cycle
// Notes: decoded parameters follow the words captured at each start-up event

`timescale 1ns/1ps

module msc_startup_config
  import msc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic startup_begin_in,
  output logic [15:0] reg_rdata_out,
  output logic reg_rvalid_out,
  output logic params_valid_out,
  output msc_brake_t brake_params_out,
  output msc_accel_t accel_params_out
);

  // ------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------
  logic [15:0] brake_word;
  logic [15:0] accel_word;
  logic [15:0] active_brake;
  logic [15:0] active_accel;
  logic snap_pending;

  wire hit_brake = (reg_addr_in == MSC_ADDR_BRAKE);
  wire hit_accel = (reg_addr_in == MSC_ADDR_ACCEL);
  wire wr_brake = reg_write_in && hit_brake;
  wire wr_accel = reg_write_in && hit_accel;
  // reserved top bit is never stored, so it cannot read back as one
  wire [15:0] next_accel = reg_wdata_in & MSC_ACCEL_WMASK;
  // unmapped addresses answer with zero rather than stale data
  wire [15:0] next_rdata = hit_brake ? brake_word :
                           hit_accel ? accel_word : MSC_READ_IDLE;

  // ------------------------------------------------------------
  // configuration words
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      brake_word <= MSC_WORD_RESET;
      accel_word <= MSC_WORD_RESET;
    end else begin
      if (wr_brake) begin
        brake_word <= reg_wdata_in;
      end
      if (wr_accel) begin
        accel_word <= next_accel;
      end
    end
  end

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= MSC_READ_IDLE;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rdata_out <= reg_read_in ? next_rdata : MSC_READ_IDLE;
      reg_rvalid_out <= reg_read_in;
    end
  end

  // ------------------------------------------------------------
  // start-up snapshot
  // ------------------------------------------------------------
  // words are frozen at the start so a write mid-sequence cannot change the
  // profile of a spin-up already under way; a same-cycle write lands next time
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      active_brake <= MSC_WORD_RESET;
      active_accel <= MSC_WORD_RESET;
      snap_pending <= 1'b0;
      params_valid_out <= 1'b0;
    end else begin
      if (startup_begin_in) begin
        active_brake <= brake_word;
        active_accel <= accel_word;
      end
      snap_pending <= startup_begin_in;
      if (snap_pending) begin
        params_valid_out <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // decoders
  // ------------------------------------------------------------
  msc_brake_decode u_brake (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .word_in(active_brake),
    .params_out(brake_params_out)
  );

  msc_accel_decode u_accel (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .word_in(active_accel),
    .params_out(accel_params_out)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  chk_reserved_reads_zero: assert property (reg_rvalid_out |-> !reg_rdata_out[15]
      || $past(reg_addr_in) == MSC_ADDR_BRAKE)
    else $error("reserved bit read back as one");
  chk_reserved_never_set: assert property (!accel_word[15])
    else $error("reserved bit stored");
  chk_reset_words: assert property ($past(rst_in) |-> brake_word == 16'h0000
      && accel_word == 16'h0000 && !params_valid_out)
    else $error("words not zero after reset");
  chk_write_brake_addr: assert property (wr_brake |=> brake_word == $past(reg_wdata_in))
    else $error("write at brake address lost");
  chk_read_brake_addr: assert property (reg_read_in && hit_brake && !wr_brake |=>
      reg_rvalid_out && reg_rdata_out == $past(brake_word))
    else $error("read of brake word wrong");
  chk_unmapped_zero: assert property (reg_read_in && !hit_brake && !hit_accel |=>
      reg_rdata_out == 16'h0000)
    else $error("unmapped read not zero");
  chk_snapshot_hold: assert property (!startup_begin_in |=> $stable(active_brake)
      && $stable(active_accel))
    else $error("active words changed outside start-up");
  chk_snapshot_flow: assert property (startup_begin_in |-> ##2
      brake_params_out.initial_speed_detect_enable == $past(brake_word[MSC_ISD_BIT], 2)
      && params_valid_out)
    else $error("start-up parameters not taken from words");

  cov_startup_isd: cover property (startup_begin_in && brake_word[MSC_ISD_BIT] ##2
      brake_params_out.initial_speed_detect_enable);
  cov_brake_off: cover property (startup_begin_in && brake_word[2:0] == 3'h0);
  cov_handover_hi: cover property (##1 accel_params_out.handover_freq > 12'h076);
  cov_write_during_start: cover property (startup_begin_in && reg_write_in);

endmodule

// file: verification/tb_msc_startup_config.sv
// Purpose: self-checking bench for the start-up configuration words and their decode
// Assumes: strobe register port, one access a cycle, start-up pulse snapshots both words
// Notes: expected values are worked out by hand in the units of the package carriers

`timescale 1ns/1ps

module tb_msc_startup_config
  import msc_pkg::*;
;
  logic clk_in, rst_in, reg_write_in, reg_read_in, startup_begin_in;
  logic [7:0] reg_addr_in;
  logic [15:0] reg_wdata_in, reg_rdata_out;
  logic reg_rvalid_out, params_valid_out;
  msc_brake_t bp;
  msc_accel_t ap;
  int errors, samples_checked;

  msc_startup_config msc_startup_config_i (
    .clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
    .reg_read_in(reg_read_in), .startup_begin_in(startup_begin_in),
    .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
    .params_valid_out(params_valid_out), .brake_params_out(bp),
    .accel_params_out(ap));

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_write_in = 1'b1;
    @(posedge clk_in);
    #1 reg_write_in = 1'b0;
  endtask

  // answer lands on the taking edge's update, gone one cycle later
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    reg_addr_in = a;
    reg_read_in = 1'b1;
    @(posedge clk_in);
    #1 reg_read_in = 1'b0;
    chk("rvalid", 32'h1, reg_rvalid_out);
    chk("rdata", exp, reg_rdata_out);
    @(posedge clk_in);
    #1 chk("rdata idle", 32'h0, reg_rdata_out);
  endtask

  task automatic start();
    startup_begin_in = 1'b1;
    @(posedge clk_in);
    #1 startup_begin_in = 1'b0;
    @(posedge clk_in);
    #1 chk("params valid", 32'h1, params_valid_out);
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rd(MSC_ADDR_BRAKE, 16'h0000);
    rd(MSC_ADDR_ACCEL, 16'h0000);
    chk("params valid idle", 32'h0, params_valid_out);
    start();
    chk("stationary ms", 32'd80, bp.stationary_ms);
    chk("brake en", 32'h0, bp.brake_enable);
    chk("isd en", 32'h0, bp.initial_speed_detect_enable);
    chk("align ms", 32'd5300, ap.align_ms);
    chk("handover valid", 32'h0, ap.handover_valid);
  endtask

  task automatic t_brake_all();
    wr(MSC_ADDR_BRAKE, 16'hffff);
    repeat (2) @(posedge clk_in);
    #1 chk("no snap stationary", 32'd80, bp.stationary_ms);
    rd(MSC_ADDR_BRAKE, 16'hffff);
    start();
    chk("stationary freq", 32'd8, bp.stationary_freq);
    chk("stationary ms", 32'd640, bp.stationary_ms);
    chk("brake cur", 32'd48, bp.brake_current_ma);
    chk("hysteresis", 32'd40, bp.hysteresis_mv);
    chk("isd en", 32'h1, bp.initial_speed_detect_enable);
    chk("reverse en", 32'h1, bp.reverse_drive_enable);
    chk("reverse thr", 32'd510, bp.reverse_threshold);
    chk("open loop ma", 32'd1600, bp.open_loop_current_ma);
    chk("align cur ma", 32'd1200, bp.align_current_ma);
    chk("ramp", 32'd23, bp.ramp_rate);
    chk("brake en", 32'h1, bp.brake_enable);
    chk("brake ms", 32'd40, bp.brake_duration_ms);
  endtask

  task automatic t_accel_top();
    wr(MSC_ADDR_ACCEL, 16'hffff);
    rd(MSC_ADDR_ACCEL, 16'h7fff);
    start();
    chk("range slow", 32'h1, ap.range_slow);
    chk("accel2", 32'h0, ap.accel_second_order);
    chk("accel1", 32'd19, ap.accel_first_order);
    chk("handover", 32'd2039, ap.handover_freq);
    chk("align ms", 32'd40, ap.align_ms);
  endtask

  // unmapped write must not land in either word
  task automatic t_accel_low();
    wr(8'h94, 16'h1234);
    rd(8'h94, 16'h0000);
    rd(MSC_ADDR_ACCEL, 16'h7fff);
    rd(MSC_ADDR_BRAKE, 16'hffff);
    wr(MSC_ADDR_ACCEL, 16'h0008);
    start();
    chk("range fast", 32'h0, ap.range_slow);
    chk("accel2", 32'd570000, ap.accel_second_order);
    chk("accel1", 32'd76000, ap.accel_first_order);
    chk("handover valid", 32'h1, ap.handover_valid);
    chk("handover", 32'd8, ap.handover_freq);
    chk("align ms", 32'd5300, ap.align_ms);
  endtask

  // middle codes; a write in the start-up cycle lands but misses this snapshot
  task automatic t_mid_codes();
    wr(MSC_ADDR_ACCEL, 16'h4283);
    rd(MSC_ADDR_ACCEL, 16'h4283);
    wr(MSC_ADDR_BRAKE, 16'h4199);
    @(posedge clk_in);
    #1 reg_wdata_in = 16'h0000;
    reg_write_in = 1'b1;
    startup_begin_in = 1'b1;
    @(posedge clk_in);
    #1 reg_write_in = 1'b0;
    startup_begin_in = 1'b0;
    @(posedge clk_in);
    #1 chk("params valid", 32'h1, params_valid_out);
    chk("stationary freq", 32'd30, bp.stationary_freq);
    chk("stationary ms", 32'd160, bp.stationary_ms);
    chk("brake cur", 32'd24, bp.brake_current_ma);
    chk("hysteresis", 32'd20, bp.hysteresis_mv);
    chk("isd en", 32'h0, bp.initial_speed_detect_enable);
    chk("reverse en", 32'h0, bp.reverse_drive_enable);
    chk("reverse thr", 32'd130, bp.reverse_threshold);
    chk("open loop ma", 32'd800, bp.open_loop_current_ma);
    chk("align cur ma", 32'd600, bp.align_current_ma);
    chk("ramp", 32'd700, bp.ramp_rate);
    chk("brake ms", 32'd2700, bp.brake_duration_ms);
    chk("range slow", 32'h1, ap.range_slow);
    chk("accel2", 32'd2200, ap.accel_second_order);
    chk("accel1", 32'd1200, ap.accel_first_order);
    chk("handover", 32'd119, ap.handover_freq);
    chk("handover valid", 32'h1, ap.handover_valid);
    chk("align ms", 32'd670, ap.align_ms);
    rd(MSC_ADDR_BRAKE, 16'h0000);
    chk("brake ms held", 32'd2700, bp.brake_duration_ms);
  endtask

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    errors = 0;
    samples_checked = 0;
    rst_in = 1'b1;
    reg_write_in = 1'b0;
    reg_read_in = 1'b0;
    startup_begin_in = 1'b0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 16'h0000;
    repeat (10) @(posedge clk_in);
    #1 rst_in = 1'b0;
    t_reset();
    t_brake_all();
    t_accel_top();
    t_accel_low();
    t_mid_codes();
    close_out();
  end

  // whole run needs well under 200 cycles
  initial begin
    #8000;
    errors++;
    close_out();
  end
endmodule
